//--- rtl/secc_pkg.sv
package secc_pkg;

  // Opcodes
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h42;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OP_FULL_ERASE = 8'hC7;
  localparam logic [7:0] OP_WAKE_SIGNATURE = 8'hAB;
  localparam logic [7:0] OP_SLEEP = 8'hB9;

  // Status byte fields
  localparam int SR_WRITE_IN_PROGRESS = 0;
  localparam int SR_WRITE_LATCH = 1;
  localparam int SR_BLOCK_PROTECT_LO = 2;
  localparam int SR_BLOCK_PROTECT_HI = 3;
  localparam int SR_PROTECT_PIN_ENABLE = 7;
  localparam logic [2:0] SR_UNUSED_BITS = 3'h0;

  // Nonvolatile field values after power-up of a fresh part
  localparam logic [1:0] BLOCK_PROTECT_RESET = 2'h0;
  localparam logic PROTECT_PIN_ENABLE_RESET = 1'b0;

  // Block protect encodings
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;

  // Array geometry
  localparam int ARRAY_ADDR_W = 17;
  localparam int PAGE_ADDR_W = 8;
  localparam int SECTOR_ADDR_W = 15;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Serial framing
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] ADDR_BYTE_FIRST = 2'h0;
  localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;

  // Arbitrary signature value
  localparam logic [7:0] SIGNATURE = 8'h5A;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_CYCLE_US = 6000;
  localparam int ERASE_CYCLE_US = 10000;
  localparam int WRITE_CYCLES_DEF = WRITE_CYCLE_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES_DEF = ERASE_CYCLE_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;

  typedef enum logic [3:0] {
    PH_OPCODE,
    PH_ADDRESS,
    PH_NO_ARGUMENT,
    PH_READ_DATA,
    PH_WRITE_DATA,
    PH_STATUS_WRITE,
    PH_STATUS_READ,
    PH_SIGNATURE,
    PH_IGNORE
  } secc_phase_t;

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_last;
    logic wp_meta;
    logic wp_sync;
    logic write_latch_bit;
    logic protect_pin_enable;
    logic [1:0] block_protect;
    logic write_in_progress;
    logic asleep;
    logic [TIMER_W-1:0] timer;
  } secc_sys_t;

endpackage : secc_pkg

//--- rtl/secc_core.sv
// Behaviour
// - Opcode shifted into 8-bit register on rise
// - All bytes move most significant bit first
// - First bit taken on first edge after select
// - Pause freezes state; release resumes exactly
// - Decode read, write, latch-set opcodes
// - Decode latch-clear, status read, status write
// - Recognise page, sector, full erase opcodes
// - Recognise wake-signature and sleep opcodes
// - Read: opcode, 24-bit address, then data
// - Read address increments, wraps top to zero
// - Read ends on deselect; output released
// - Latch set needs deselect after opcode
// - Write cycle includes its own erase
// - Write carries 1 to 256 in-page bytes
// - Partial page keeps unchanged bytes rewritten
// - Write address wraps inside the page
// - Commit only on deselect at byte end
// - Busy refuses array reads, allows status reads
// - Latch set/clear; clear latch blocks writes
// - Latch cleared at reset and after accepted write, erase, status write
// - Status byte field layout
// - Progress bit tracks write cycle, read-only
// - Latch commands work despite status protection
// - Block protect changes only by status write
// - Block protect ranges block array writes
// - Pin enable plus low pin locks status
`timescale 1ns/100ps
`default_nettype none

module secc_core #(
  parameter int ADDR_W = secc_pkg::ARRAY_ADDR_W,
  parameter int PAGE_W = secc_pkg::PAGE_ADDR_W,
  parameter int SECTOR_W = secc_pkg::SECTOR_ADDR_W,
  parameter int WRITE_CYCLES = secc_pkg::WRITE_CYCLES_DEF,
  parameter int ERASE_CYCLES = secc_pkg::ERASE_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int PAGE = 1 << PAGE_W;
  localparam logic [ADDR_W-1:0] PAGE_MASK = {ADDR_W{1'b1}} << PAGE_W;
  localparam logic [ADDR_W-1:0] SECTOR_MASK = {ADDR_W{1'b1}} << SECTOR_W;
  localparam logic [ADDR_W-1:0] FULL_MASK = {ADDR_W{1'b0}};
  localparam logic [secc_pkg::TIMER_W-1:0] WRITE_TIME = secc_pkg::TIMER_W'(WRITE_CYCLES);
  localparam logic [secc_pkg::TIMER_W-1:0] ERASE_TIME = secc_pkg::TIMER_W'(ERASE_CYCLES);
  localparam logic [secc_pkg::TIMER_W-1:0] TIMER_ONE = secc_pkg::TIMER_W'(1);
  localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'(1);
  localparam logic [PAGE_W-1:0] PAGE_ONE = PAGE_W'(1);

  if (ADDR_W < 3 || ADDR_W > 24 || PAGE_W < 1 || SECTOR_W <= PAGE_W || SECTOR_W >= ADDR_W) begin : g_bad_geometry
    $error("secc_core: unsupported array geometry");
  end
  if (WRITE_CYCLES < 1 || ERASE_CYCLES < 1 || WRITE_CYCLES >= (1 << secc_pkg::TIMER_W)
      || ERASE_CYCLES >= (1 << secc_pkg::TIMER_W)) begin : g_bad_timing
    $error("secc_core: cycle counts out of timer range");
  end

  typedef struct packed {
    secc_pkg::secc_phase_t st;
    logic [2:0] bitc;
    logic [1:0] abyte;
    logic [7:0] sh;
    logic [7:0] opc;
    logic [15:0] adr;
    logic [ADDR_W-1:0] ptr;
    logic [7:0] tx_byte;
    logic tx_on;
    logic wr_any;
    logic sr_any;
    logic [7:0] sr_new;
    logic [8:0] sync_meta;
    logic [8:0] sync_q;
    logic [PAGE-1:0] pmask;
    logic [PAGE-1:0][7:0] pbuf;
  } secc_link_t;

  secc_link_t l;
  secc_link_t next_l;
  secc_pkg::secc_sys_t s;
  secc_pkg::secc_sys_t next_s;
  logic [7:0] mem [DEPTH];
  logic live;
  logic so_q;
  logic [7:0] status_byte;
  logic [2:0] cb;
  logic [7:0] b;
  logic [ADDR_W-1:0] full_adr;
  logic link_asleep;
  logic link_busy;
  logic frame_end;
  logic hw_prot;
  logic noarg_ok;
  logic do_wr;
  logic do_erase;
  logic [ADDR_W-1:0] er_mask;

  function automatic logic array_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    case (bp)
      secc_pkg::BP_QUARTER: array_protected = &a[ADDR_W-1 -: 2];
      secc_pkg::BP_HALF: array_protected = a[ADDR_W-1];
      secc_pkg::BP_ALL: array_protected = 1'b1;
      default: array_protected = 1'b0;
    endcase
  endfunction : array_protected

  // Status byte as seen by the host
  always_comb begin
    status_byte = 8'h00;
    status_byte[secc_pkg::SR_PROTECT_PIN_ENABLE] = s.protect_pin_enable;
    status_byte[6:4] = secc_pkg::SR_UNUSED_BITS;
    status_byte[secc_pkg::SR_BLOCK_PROTECT_HI] = s.block_protect[1];
    status_byte[secc_pkg::SR_BLOCK_PROTECT_LO] = s.block_protect[0];
    status_byte[secc_pkg::SR_WRITE_LATCH] = s.write_latch_bit;
    status_byte[secc_pkg::SR_WRITE_IN_PROGRESS] = s.write_in_progress;
  end

  // Frame marker: cleared while deselected, set by the first edge of a frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      live <= 1'b0;
    end else if (hold_n) begin
      live <= 1'b1;
    end
  end

  assign link_asleep = l.sync_q[8];
  assign link_busy = l.sync_q[secc_pkg::SR_WRITE_IN_PROGRESS];

  // Link side: serial decode on the rising edge of the serial clock
  always_comb begin
    next_l = l;
    cb = secc_pkg::BIT_FIRST;
    b = 8'h00;
    full_adr = '0;
    next_l.sync_meta = {s.asleep, status_byte};
    next_l.sync_q = l.sync_meta;
    if (hold_n) begin
      if (!live) begin
        next_l.st = secc_pkg::PH_OPCODE;
        next_l.bitc = secc_pkg::BIT_FIRST;
        next_l.abyte = secc_pkg::ADDR_BYTE_FIRST;
        next_l.tx_on = 1'b0;
        next_l.wr_any = 1'b0;
        next_l.sr_any = 1'b0;
      end
      cb = next_l.bitc;
      b = {next_l.sh[6:0], si};
      next_l.sh = b;
      next_l.bitc = cb + 3'h1;
      full_adr = ADDR_W'({next_l.adr, b});
      if (cb == secc_pkg::BIT_LAST) begin
        case (next_l.st)
          secc_pkg::PH_OPCODE: begin
            next_l.opc = b;
            next_l.abyte = secc_pkg::ADDR_BYTE_FIRST;
            if (link_asleep && b != secc_pkg::OP_WAKE_SIGNATURE) begin
              next_l.st = secc_pkg::PH_IGNORE;
            end else begin
              case (b)
                secc_pkg::OP_ARRAY_READ: next_l.st = link_busy ? secc_pkg::PH_IGNORE : secc_pkg::PH_ADDRESS;
                secc_pkg::OP_ARRAY_WRITE: begin
                  next_l.st = link_busy ? secc_pkg::PH_IGNORE : secc_pkg::PH_ADDRESS;
                  next_l.pmask = '0;
                end
                secc_pkg::OP_PAGE_ERASE,
                secc_pkg::OP_SECTOR_ERASE,
                secc_pkg::OP_WAKE_SIGNATURE: next_l.st = secc_pkg::PH_ADDRESS;
                secc_pkg::OP_LATCH_SET,
                secc_pkg::OP_LATCH_CLEAR,
                secc_pkg::OP_FULL_ERASE,
                secc_pkg::OP_SLEEP: next_l.st = secc_pkg::PH_NO_ARGUMENT;
                secc_pkg::OP_STATUS_READ: begin
                  next_l.st = secc_pkg::PH_STATUS_READ;
                  next_l.tx_byte = l.sync_q[7:0];
                  next_l.tx_on = 1'b1;
                end
                secc_pkg::OP_STATUS_WRITE: next_l.st = secc_pkg::PH_STATUS_WRITE;
                default: next_l.st = secc_pkg::PH_IGNORE;
              endcase
            end
          end
          secc_pkg::PH_ADDRESS: begin
            next_l.adr = {next_l.adr[7:0], b};
            if (next_l.abyte == secc_pkg::ADDR_BYTE_LAST) begin
              next_l.ptr = full_adr;
              case (next_l.opc)
                secc_pkg::OP_ARRAY_READ: begin
                  next_l.st = secc_pkg::PH_READ_DATA;
                  next_l.tx_byte = mem[full_adr];
                  next_l.ptr = full_adr + ADDR_ONE;
                  next_l.tx_on = 1'b1;
                end
                secc_pkg::OP_ARRAY_WRITE: next_l.st = secc_pkg::PH_WRITE_DATA;
                secc_pkg::OP_WAKE_SIGNATURE: begin
                  next_l.st = secc_pkg::PH_SIGNATURE;
                  next_l.tx_byte = secc_pkg::SIGNATURE;
                  next_l.tx_on = 1'b1;
                end
                default: next_l.st = secc_pkg::PH_NO_ARGUMENT;
              endcase
            end
            next_l.abyte = next_l.abyte + 2'h1;
          end
          secc_pkg::PH_READ_DATA: begin
            next_l.tx_byte = mem[next_l.ptr];
            next_l.ptr = next_l.ptr + ADDR_ONE;
          end
          secc_pkg::PH_STATUS_READ: next_l.tx_byte = l.sync_q[7:0];
          secc_pkg::PH_WRITE_DATA: begin
            next_l.pbuf[next_l.ptr[PAGE_W-1:0]] = b;
            next_l.pmask[next_l.ptr[PAGE_W-1:0]] = 1'b1;
            next_l.ptr = {next_l.ptr[ADDR_W-1:PAGE_W], PAGE_W'(next_l.ptr[PAGE_W-1:0] + PAGE_ONE)};
            next_l.wr_any = 1'b1;
          end
          secc_pkg::PH_STATUS_WRITE: begin
            if (!next_l.sr_any) begin
              next_l.sr_new = b;
              next_l.sr_any = 1'b1;
            end
          end
          secc_pkg::PH_NO_ARGUMENT: next_l.st = secc_pkg::PH_IGNORE;
          default: next_l.st = next_l.st;
        endcase
      end
    end
  end

  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      l <= '{st: secc_pkg::PH_IGNORE, default: '0};
    end else begin
      l <= next_l;
    end
  end

  // Output bit changes on the falling edge, ahead of the host's sampling edge
  always_ff @(negedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      so_q <= 1'b0;
    end else if (hold_n) begin
      so_q <= l.tx_byte[secc_pkg::BIT_LAST - l.bitc];
    end
  end

  assign so = so_q;
  assign so_oe = ~cs_n & hold_n & live & l.tx_on;

  // System side: commit on deselect, protection, write cycle timing
  always_comb begin
    next_s = s;
    next_s.cs_meta = cs_n;
    next_s.cs_sync = s.cs_meta;
    next_s.cs_last = s.cs_sync;
    next_s.wp_meta = wp_n;
    next_s.wp_sync = s.wp_meta;
    frame_end = s.cs_sync & ~s.cs_last;
    hw_prot = s.protect_pin_enable & ~s.wp_sync;
    noarg_ok = l.st == secc_pkg::PH_NO_ARGUMENT && l.bitc == secc_pkg::BIT_FIRST;
    do_wr = 1'b0;
    do_erase = 1'b0;
    er_mask = FULL_MASK;
    if (s.write_in_progress) begin
      next_s.timer = s.timer - TIMER_ONE;
      if (s.timer == TIMER_ONE) begin
        next_s.write_in_progress = 1'b0;
      end
    end
    if (frame_end && (!s.asleep || l.opc == secc_pkg::OP_WAKE_SIGNATURE)) begin
      case (l.opc)
        secc_pkg::OP_LATCH_SET: begin
          if (noarg_ok) begin
            next_s.write_latch_bit = 1'b1;
          end
        end
        secc_pkg::OP_LATCH_CLEAR: begin
          if (noarg_ok) begin
            next_s.write_latch_bit = 1'b0;
          end
        end
        secc_pkg::OP_SLEEP: begin
          if (noarg_ok) begin
            next_s.asleep = 1'b1;
          end
        end
        secc_pkg::OP_WAKE_SIGNATURE: begin
          if (l.st != secc_pkg::PH_OPCODE) begin
            next_s.asleep = 1'b0;
          end
        end
        secc_pkg::OP_ARRAY_WRITE: begin
          if (l.st == secc_pkg::PH_WRITE_DATA && l.bitc == secc_pkg::BIT_FIRST && l.wr_any
              && s.write_latch_bit && !s.write_in_progress
              && !array_protected(s.block_protect, l.ptr)) begin
            do_wr = 1'b1;
            next_s.write_latch_bit = 1'b0;
            next_s.write_in_progress = 1'b1;
            next_s.timer = WRITE_TIME;
          end
        end
        secc_pkg::OP_PAGE_ERASE,
        secc_pkg::OP_SECTOR_ERASE,
        secc_pkg::OP_FULL_ERASE: begin
          er_mask = (l.opc == secc_pkg::OP_PAGE_ERASE) ? PAGE_MASK
                  : (l.opc == secc_pkg::OP_SECTOR_ERASE) ? SECTOR_MASK : FULL_MASK;
          if (noarg_ok && s.write_latch_bit && !s.write_in_progress
              && ((l.opc == secc_pkg::OP_FULL_ERASE) ? s.block_protect == secc_pkg::BP_NONE
                  : !array_protected(s.block_protect, l.ptr & er_mask))) begin
            do_erase = 1'b1;
            next_s.write_latch_bit = 1'b0;
            next_s.write_in_progress = 1'b1;
            next_s.timer = (l.opc == secc_pkg::OP_PAGE_ERASE) ? WRITE_TIME : ERASE_TIME;
          end
        end
        secc_pkg::OP_STATUS_WRITE: begin
          if (l.st == secc_pkg::PH_STATUS_WRITE && l.bitc == secc_pkg::BIT_FIRST && l.sr_any
              && s.write_latch_bit && !s.write_in_progress && !hw_prot) begin
            next_s.protect_pin_enable = l.sr_new[secc_pkg::SR_PROTECT_PIN_ENABLE];
            next_s.block_protect = {l.sr_new[secc_pkg::SR_BLOCK_PROTECT_HI],
                                    l.sr_new[secc_pkg::SR_BLOCK_PROTECT_LO]};
            next_s.write_latch_bit = 1'b0;
            next_s.write_in_progress = 1'b1;
            next_s.timer = WRITE_TIME;
          end
        end
        default: next_s.asleep = s.asleep;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{cs_meta: 1'b1, cs_sync: 1'b1, cs_last: 1'b1, wp_meta: 1'b1, wp_sync: 1'b1,
             block_protect: secc_pkg::BLOCK_PROTECT_RESET,
             protect_pin_enable: secc_pkg::PROTECT_PIN_ENABLE_RESET,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  // Array storage; a partial page leaves its other bytes as they were
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      for (int i = 0; i < PAGE; i++) begin
        if (l.pmask[i]) begin
          mem[{l.ptr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= l.pbuf[i];
        end
      end
    end
    if (do_erase) begin
      for (int i = 0; i < DEPTH; i++) begin
        if ((ADDR_W'(i) & er_mask) == (l.ptr & er_mask)) begin
          mem[i] <= secc_pkg::ERASED_BYTE;
        end
      end
    end
  end

endmodule : secc_core

`default_nettype wire

//--- dv/secc_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module secc_assertions (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe
);
  logic [9:0] rises;
  logic [7:0] opcode;
  logic known;

  // Counts unpaused rising edges and captures the opcode of the frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rises <= 10'h000;
      opcode <= 8'h00;
    end else if (hold_n) begin
      if (rises != 10'h3FF) begin
        rises <= rises + 10'h001;
      end
      if (rises < 10'h008) begin
        opcode <= {opcode[6:0], si};
      end
    end
  end

  assign known = (opcode == 8'h03) || (opcode == 8'h05) || (opcode == 8'hAB);

  sequence s_paused;
    !hold_n;
  endsequence

  sequence s_status_gap;
    opcode == 8'h05 && so_oe && rises >= 10'h008 && rises[2:0] inside {3'h1, 3'h2, 3'h3};
  endsequence

  chk_oe_selected: assert property (@(posedge sys_clk) disable iff (sys_rst) so_oe |-> !cs_n)
    else $error("so driven while deselected");
  chk_oe_unpaused: assert property (@(posedge sys_clk) disable iff (sys_rst) so_oe |-> hold_n)
    else $error("so driven while paused");
  chk_no_early_out: assert property (@(posedge sck) disable iff (sys_rst || cs_n) rises < 10'h008 |-> !so_oe)
    else $error("so driven before opcode complete");
  chk_read_addr_quiet: assert property (@(posedge sck) disable iff (sys_rst || cs_n)
    opcode == 8'h03 && rises < 10'h020 |-> !so_oe)
    else $error("read data driven before address complete");
  chk_unknown_quiet: assert property (@(posedge sck) disable iff (sys_rst || cs_n)
    rises >= 10'h008 && !known |-> !so_oe)
    else $error("so driven for opcode without output");
  chk_status_unused: assert property (@(posedge sck) disable iff (sys_rst || cs_n) s_status_gap |-> !so)
    else $error("unused status bit not zero");
  chk_signature_bits: assert property (@(posedge sck) disable iff (sys_rst || cs_n)
    opcode == 8'hAB && so_oe && rises >= 10'h020 |-> so == secc_pkg::SIGNATURE[~rises[2:0]])
    else $error("signature bit wrong");
  chk_hold_freeze: assert property (@(negedge sck) disable iff (sys_rst || cs_n) s_paused |=> $stable(so))
    else $error("so changed while paused");
endmodule : secc_assertions

bind secc_core secc_assertions chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
  .hold_n(hold_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe));

`default_nettype wire

//--- dv/secc_host.sv
`timescale 1ns/100ps
`default_nettype none

module secc_host (
  output var logic sck,
  output var logic cs_n,
  output var logic hold_n,
  output var logic si,
  input wire logic so,
  input wire logic so_oe
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    si = 1'b0;
  end

  // Pause with the clock still running and data toggling
  task automatic hold_pause;
    hold_n = 1'b0;
    repeat (3) begin
      si = ~si;
      #7.5 sck = 1'b1;
      #7.5 sck = 1'b0;
    end
    hold_n = 1'b1;
  endtask : hold_pause

  // One frame; the last byte carries tail bits, clock idle low between frames
  task automatic frame(input logic [7:0] tx[$], input int tail, input int pause_at,
                       output logic [7:0] rx[$], output logic oe);
    logic [7:0] b;
    int n;
    rx = {};
    oe = 1'b0;
    b = 8'h00;
    cs_n = 1'b0;
    #20;
    foreach (tx[i]) begin
      n = (i == tx.size() - 1) ? tail : 8;
      for (int k = 7; k >= 8 - n; k--) begin
        if (i * 8 + 7 - k == pause_at) hold_pause();
        si = tx[i][k];
        #7.5 sck = 1'b1;
        b[k] = so_oe ? so : ~so;
        oe = oe | so_oe;
        #7.5 sck = 1'b0;
      end
      rx.push_back(b);
    end
    #20 cs_n = 1'b1;
    si = ~si;
    #600;
  endtask : frame
endmodule : secc_host

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic sys_clk;
  logic sys_rst;
  logic wp_n;
  wire logic sck;
  wire logic cs_n;
  wire logic hold_n;
  wire logic si;
  wire logic so;
  wire logic so_oe;
  logic [7:0] rx[$];
  logic [7:0] ers[2];
  logic [23:0] era[2];
  logic oe;
  int mismatches;
  int samples_checked;
  int cycles;

  secc_core #(.ADDR_W(12), .SECTOR_W(10), .WRITE_CYCLES(30), .ERASE_CYCLES(40)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
    .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe));

  secc_host host_u (.sck(sck), .cs_n(cs_n), .hold_n(hold_n), .si(si), .so(so), .so_oe(so_oe));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic run(input logic [7:0] tx[$], input int tail = 8, input int pause_at = -1);
    host_u.frame(tx, tail, pause_at, rx, oe);
  endtask : run

  task automatic status(input logic [7:0] exp, input string name);
    run({8'h05, 8'h00, 8'h00});
    check(name, exp, rx[2]);
  endtask : status

  task automatic rd(input logic [23:0] a, input int p = -1);
    run({8'h03, a[23:16], a[15:8], a[7:0], 8'h00, 8'h00, 8'h00}, 8, p);
  endtask : rd

  task automatic settle;
    repeat (80) @(posedge sys_clk);
  endtask : settle

  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    run({8'h06});
    run({8'h02, a[23:16], a[15:8], a[7:0], d});
    settle();
  endtask : wr

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  initial begin
    sys_rst = 1'b1;
    wp_n = 1'b1;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    ers = '{8'h42, 8'hD8};
    era = '{24'h0000FE, 24'h000400};
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    status(8'h00, "status after reset");
    run({8'h06});
    status(8'h02, "latch set");
    run({8'hC7});
    status(8'h01, "full erase busy");
    settle();
    done("latch and erase");
    run({8'h06});
    run({8'h02, 8'h00, 8'h00, 8'hFE, 8'hA1, 8'hB2, 8'hC3});
    rd(24'h0000FE);
    check("array read while busy", 8'h00, {7'h00, oe});
    status(8'h01, "write busy");
    settle();
    rd(24'hFE0FFF);
    check("top byte", 8'hFF, rx[4]);
    check("wrapped byte", 8'hC3, rx[5]);
    check("after wrap", 8'hFF, rx[6]);
    wr(24'h0000FF, 8'h11);
    rd(24'h0000FE, 14);
    check("kept byte", 8'hA1, rx[4]);
    check("rewritten byte", 8'h11, rx[5]);
    done("page write");
    run({8'h02, 8'h00, 8'h00, 8'h10, 8'h55});
    status(8'h00, "write without latch");
    run({8'h06, 8'h02, 8'h00, 8'h00, 8'h10, 8'h55});
    status(8'h00, "latch without deselect");
    run({8'h06});
    run({8'h02, 8'h00, 8'h00, 8'h10, 8'h77}, 5);
    status(8'h02, "aborted write");
    rd(24'h000010);
    check("unwritten byte", 8'hFF, rx[4]);
    run({8'h04});
    status(8'h00, "latch clear");
    done("write guards");
    wr(24'h000000, 8'h8C);
    run({8'h06});
    run({8'h01, 8'h8C});
    settle();
    status(8'h8C, "status write");
    wr(24'h000100, 8'h66);
    rd(24'h000100);
    check("all protected byte", 8'hFF, rx[4]);
    @(posedge sys_clk) wp_n <= 1'b0;
    run({8'h06});
    run({8'h01, 8'h00});
    settle();
    status(8'h8E, "locked status");
    @(posedge sys_clk) wp_n <= 1'b1;
    run({8'h06});
    run({8'h01, 8'h04});
    settle();
    status(8'h04, "unlocked status");
    wr(24'h000C00, 8'h12);
    wr(24'h000400, 8'h34);
    rd(24'h000C00);
    check("protected byte", 8'hFF, rx[4]);
    rd(24'h000400);
    check("open byte", 8'h34, rx[4]);
    done("protection");
    foreach (ers[i]) begin
      run({8'h06});
      run({ers[i], era[i][23:16], era[i][15:8], era[i][7:0]});
      settle();
      rd(era[i]);
      check("erased byte", 8'hFF, rx[4]);
    end
    run({8'h9F, 8'h00, 8'h00});
    check("unknown opcode output", 8'h00, {7'h00, oe});
    run({8'hB9});
    run({8'h05, 8'h00, 8'h00});
    check("asleep status output", 8'h00, {7'h00, oe});
    run({8'hAB, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    check("signature", secc_pkg::SIGNATURE, rx[4]);
    status(8'h04, "awake status");
    done("erase and power");
    complete_run();
  end
endmodule : testbench

`default_nettype wire
